/* bench/prc_top_assertions.sv */
// concurrent checks on the ports of the port remap block
`timescale 1ns/1ps
module prc_top_assertions (
    input wire logic       sys_clk,
    input wire logic       sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_wr_en,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_rd_en,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_bit_set,
    input wire logic       reg_bit_clr,
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pin_pullup_on,
    input wire logic [7:0] pin_analog_on,
    input wire logic       adc_power_on,
    input wire logic       timer0_output_en,
    input wire logic       timer1_output_en,
    input wire logic       timer2_output_a_en,
    input wire logic       timer2_output_b_en,
    input wire logic       irq_input,
    input wire logic       timer0_clock_input,
    input wire logic       timer1_clock_input,
    input wire logic       timer2_clock_input,
    input wire logic       sleep_mode,
    input wire logic       wake_request
);
    logic tmr_en;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    // any timer output override hides the latch on its pin
    assign tmr_en = timer0_output_en | timer1_output_en | timer2_output_a_en | timer2_output_b_en;

    // plain read and plain write of the remap register
    sequence s_rd;
        reg_rd_en && reg_addr == 8'h04 && !reg_wr_en && !reg_bit_set && !reg_bit_clr;
    endsequence
    sequence s_wr;
        reg_wr_en && reg_addr == 8'h04 && !reg_rd_en;
    endsequence

    AST_RESET_STATE: assert property ($fell(sys_rst) |-> pin_oe == 8'h00 &&
        pin_analog_on == 8'hff && !adc_power_on && reg_rdata == 8'h00)
        else $error("reset state wrong");
    AST_UNLOCKED_WRITE: assert property (s_wr ##0 reg_wdata[7:4] == 4'ha ##1 s_wr ##1 s_rd
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'hf7))
        else $error("unlocked remap write lost");
    AST_LOCKED_WRITE: assert property (s_rd ##1 s_wr ##0 reg_rdata[7:4] != 4'ha ##1 s_rd
        |=> reg_rdata[7:4] == $past(reg_wdata[7:4], 2) &&
        reg_rdata[2:0] == $past(reg_rdata[2:0], 2))
        else $error("locked remap selection changed");
    AST_DIR_TO_OE: assert property ((reg_wr_en && reg_addr == 8'h01) ##1
        pin_analog_on == 8'h00 |-> pin_oe == ~$past(reg_wdata))
        else $error("direction write not on pin_oe");
    AST_OUTPUT_READBACK: assert property (reg_rd_en && reg_addr == 8'h00 && !reg_wr_en &&
        !reg_bit_set && !reg_bit_clr && !tmr_en
        |=> ((reg_rdata ^ $past(pin_out)) & $past(pin_oe)) == 8'h00)
        else $error("output pin read not latch");
    AST_NO_PULLUP_ANALOG: assert property ((pin_pullup_on & pin_analog_on) == 8'h00)
        else $error("pullup on analog pin");
    AST_ALL_ANALOG_QUIET: assert property (pin_analog_on == 8'hff |-> !irq_input &&
        !timer0_clock_input && !timer1_clock_input && !timer2_clock_input)
        else $error("function input active on analog pin");
    AST_WAKE_ASLEEP: assert property (wake_request |-> $past(sleep_mode))
        else $error("wake outside sleep");
endmodule

bind prc_top prc_top_assertions u_chk (
    .sys_clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata,
    .reg_bit_set, .reg_bit_clr, .pin_out, .pin_oe, .pin_pullup_on, .pin_analog_on,
    .adc_power_on, .timer0_output_en, .timer1_output_en, .timer2_output_a_en,
    .timer2_output_b_en, .irq_input, .timer0_clock_input, .timer1_clock_input,
    .timer2_clock_input, .sleep_mode, .wake_request
);

/* bench/test_prc_top.sv */
// self-checking bench with a reference model of the port remap block
`timescale 1ns/1ps
module test_prc_top;
    logic       sys_clk    = 1'b0;
    logic       sys_rst    = 1'b1;
    logic       sleep_mode = 1'b0;
    logic [3:0] strb       = 4'h0;
    logic [2:0] bit_idx    = 3'h0;
    logic [7:0] reg_addr   = 8'h00;
    logic [7:0] reg_wdata  = 8'h00;
    logic [7:0] pin_in     = 8'hff;
    logic [7:0] tmr        = 8'h00;
    logic [7:0] reg_rdata, pin_out, pin_oe, pin_pullup_on, pin_analog_on, exp_rd;
    logic [3:0] fn_in;
    logic       adc_power_on, wake_request;
    logic [7:0] m_reg [8]  = '{8'hff, 8'hff, 8'h00, 8'h00, 8'h50, 8'hff, 8'h00, 8'h00};
    int         pos [4][4] = '{'{3, 4, 5, 6}, '{3, 4, 0, 1}, '{5, 6, 2, 7}, '{2, 7, 5, 6}};
    int         num_errors = 0;
    int         num_checks = 0;
    int         cycles     = 0;
    int         seed       = 32'hf57d;
    logic [31:0] r;

    always #2.5 sys_clk = ~sys_clk;

    prc_top uut (
        .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_rdata, .pin_in, .pin_out, .pin_oe,
        .pin_pullup_on, .pin_analog_on, .adc_power_on, .sleep_mode, .wake_request,
        .reg_wr_en(strb[3]), .reg_rd_en(strb[2]), .reg_bit_set(strb[1]), .reg_bit_clr(strb[0]),
        .reg_bit_index(bit_idx), .irq_input(fn_in[3]), .timer0_clock_input(fn_in[2]),
        .timer1_clock_input(fn_in[1]), .timer2_clock_input(fn_in[0]),
        .timer0_output(tmr[0]), .timer0_output_en(tmr[1]), .timer1_output(tmr[2]),
        .timer1_output_en(tmr[3]), .timer2_output_a(tmr[4]), .timer2_output_a_en(tmr[5]),
        .timer2_output_b(tmr[6]), .timer2_output_b_en(tmr[7])
    );

    //------------------------------------------------------------
    // model and bus tasks
    //------------------------------------------------------------
    // register view as software reads it: input pins show their level
    function automatic logic [7:0] view(input logic [7:0] a);
        return (a == 8'h00) ? (m_reg[1] & pin_in | ~m_reg[1] & m_reg[0]) : m_reg[a[2:0]];
    endfunction

    // whole-register write; remap selection obeys the stored key
    function automatic void mwrite(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h04) begin
            m_reg[4] = {d[7:4], 1'b0, (m_reg[4][7:4] == 4'ha) ? d[2:0] : m_reg[4][2:0]};
        end else if (a == 8'h06) begin
            m_reg[6] = {7'h00, d[0]};
        end else if (a < 8'h06) begin
            m_reg[a[2:0]] = d;
        end
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // one register cycle driven after a rising edge, model kept in step
    task automatic op(input logic [3:0] st, input logic [7:0] a, d, input logic [2:0] i);
        @(posedge sys_clk);
        strb      <= st;
        reg_addr  <= a;
        reg_wdata <= d;
        bit_idx   <= i;
        if (st[2]) exp_rd = view(a);
        if (st[3]) mwrite(a, d);
        else if (st[1] | st[0]) mwrite(a, view(a) & ~(8'h01 << i) | ({7'h00, st[1]} << i));
    endtask

    task automatic rd(input logic [7:0] a);
        op(4'h4, a, 8'h00, 3'h0);
        op(4'h0, a, 8'h00, 3'h0);
        #1;
        chk("reg_rdata", exp_rd, reg_rdata);
    endtask

    // pin side outputs against the model
    task automatic check_pins();
        int         p [4];
        int         ip;
        logic [7:0] po;
        logic [7:0] lv;
        p  = pos[m_reg[4][1:0]];
        po = m_reg[0];
        lv = pin_in & ~m_reg[5];
        ip = m_reg[4][2] ? 7 : 3;
        if (tmr[7]) po[p[2]] = tmr[6];
        if (tmr[5]) po[p[3]] = tmr[4];
        if (tmr[3]) po[p[1]] = tmr[2];
        if (tmr[1]) po[p[0]] = tmr[0];
        chk("pin_out", po, pin_out);
        chk("pin_oe", ~m_reg[1] & ~m_reg[5], pin_oe);
        chk("pin_pullup_on", m_reg[2] & m_reg[1] & ~m_reg[5], pin_pullup_on);
        chk("pin_analog_on", m_reg[5], pin_analog_on);
        chk("adc_power_on", {7'h00, m_reg[6][0]}, {7'h00, adc_power_on});
        chk("function inputs", {4'h0, lv[ip], lv[p[1]], lv[ip], lv[p[0]]}, {4'h0, fn_in});
    endtask

    // new random pin levels and timer outputs, settle through the synchroniser
    task automatic pins_step();
        @(posedge sys_clk);
        pin_in <= 8'($random(seed));
        tmr    <= 8'($random(seed));
        repeat (5) @(posedge sys_clk);
        #1;
        check_pins();
    endtask

    // one falling edge on pin k, count the wake pulses that follow
    task automatic wake_try(input int k, input logic s, input int e);
        int n;
        n = 0;
        @(posedge sys_clk);
        sleep_mode <= s;
        pin_in     <= ~(8'h01 << k);
        for (int c = 0; c < 20; c++) begin
            @(posedge sys_clk);
            if (c == 10) pin_in <= 8'hff;
            #1;
            if (wake_request === 1'b1) n++;
        end
        chk("wake pulses", 8'(e), 8'(n));
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // main sequence
    initial begin
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 8; a++) rd(8'(a));
        check_pins();
        op(4'h8, 8'h05, 8'h00, 3'h0);
        op(4'h8, 8'h06, 8'h01, 3'h0);
        op(4'h8, 8'h00, 8'h5a, 3'h0);
        op(4'h8, 8'h01, 8'h3c, 3'h0);
        op(4'h8, 8'h02, 8'hff, 3'h0);
        rd(8'h00);
        op(4'h2, 8'h00, 8'h00, 3'h2);
        rd(8'h00);
        check_pins();
        for (int s = 0; s < 8; s++) begin
            op(4'h8, 8'h04, 8'ha0, 3'h0);
            op(4'h8, 8'h04, {5'h15, 3'(s)}, 3'h0);
            rd(8'h04);
            pins_step();
        end
        op(4'h8, 8'h04, 8'h57, 3'h0);
        op(4'h4, 8'h04, 8'h00, 3'h0);
        op(4'h8, 8'h04, 8'h32, 3'h0);
        rd(8'h04);
        repeat (80) begin
            r = $random(seed);
            if (r[10:8] == 3'h4 && r[11]) op(4'h8, 8'h04, 8'ha0, 3'h0);
            op({r[13:12] == 2'h0, 1'b0, r[13:12] == 2'h1, r[13:12] == 2'h2},
               {5'h00, r[10:8]}, r[7:0], r[16:14]);
            rd({5'h00, r[10:8]});
            pins_step();
        end
        // software setup for timer use: irq/timer1 clock high, timer code 10
        op(4'h8, 8'h04, 8'ha0, 3'h0);
        op(4'h8, 8'h04, 8'ha6, 3'h0);
        rd(8'h04);
        pins_step();
        op(4'h8, 8'h05, 8'h00, 3'h0);
        op(4'h8, 8'h03, 8'h24, 3'h0);
        op(4'h0, 8'h00, 8'h00, 3'h0);
        pin_in <= 8'hff;
        repeat (6) @(posedge sys_clk);
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 8; k++) begin
                wake_try(k, s[0], int'(s == 1 && (k == 2 || k == 5)));
            end
        end
        report_and_stop();
    end
endmodule

/* rtl/prc_defines.svh */
// register offsets, field positions, reset values and keys of the port block
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

`define PRC_ADDR_DATA      8'h00
`define PRC_ADDR_DIR       8'h01
`define PRC_ADDR_PULLUP    8'h02
`define PRC_ADDR_WAKE      8'h03
`define PRC_ADDR_REMAP     8'h04
`define PRC_ADDR_ANALOG    8'h05
`define PRC_ADDR_ADC_CTL   8'h06

`define PRC_RST_DATA       8'hff
`define PRC_RST_DIR        8'hff
`define PRC_RST_PULLUP     8'h00
`define PRC_RST_WAKE       8'h00
`define PRC_RST_KEY        4'h5
`define PRC_RST_IRQ_LOC    1'b0
`define PRC_RST_TMR_LOC    2'h0
`define PRC_RST_ANALOG     8'hff
`define PRC_RST_ADC_ON     1'b0
`define PRC_RST_SYNC       8'hff

`define PRC_KEY_UNLOCK     4'ha
`define PRC_KEY_MSB        7
`define PRC_KEY_LSB        4
`define PRC_RSV_BIT        3
`define PRC_IRQ_LOC_BIT    2
`define PRC_TMR_LOC_MSB    1
`define PRC_TMR_LOC_LSB    0
`define PRC_ADC_ON_BIT     0

`define PRC_PIN_IRQ_HI     3'h7
`define PRC_PIN_IRQ_LO     3'h3

`endif

/* rtl/prc_pkg.sv */
// types shared by the port remap block
package prc_pkg;

    // timer pin location codes
    typedef enum logic [1:0] {
        PRC_LOC_A,
        PRC_LOC_B,
        PRC_LOC_C,
        PRC_LOC_D
    } prc_timer_loc_t;

    typedef logic [2:0] prc_pin_idx_t;

endpackage

/* rtl/prc_top.sv */
// port data, direction, wake-up and pin remap control for an 8-bit port
//
// Overview of operation
// - remap key resets 0101; 1010 unlocks selection
// - remap bit 3 always reads zero
// - location bit puts irq/timer1 clock at 7/3
// - timer pin field picks one of four maps
// - data and direction reset to all ones
// - output pin drives the data latch unless its mapped timer output is enabled
// - bit set/clear is read-modify-write of port
// - shared pins reset analog, converter stays off
// - enabled analog channel removes the pull-up
// - enabled falling edge wakes sleep/idle
// - direction one is input, zero output
// - output pin reads back its latch
// - wake enables reset zero, one enables
`timescale 1ns/1ps

`include "prc_defines.svh"

module prc_top (
    input  wire logic       sys_clk,
    input  wire logic       sys_rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_rd_en,
    output logic      [7:0] reg_rdata,
    input  wire logic       reg_bit_set,
    input  wire logic       reg_bit_clr,
    input  wire logic [2:0] reg_bit_index,
    input  wire logic [7:0] pin_in,
    output logic      [7:0] pin_out,
    output logic      [7:0] pin_oe,
    output logic      [7:0] pin_pullup_on,
    output logic      [7:0] pin_analog_on,
    output logic            adc_power_on,
    input  wire logic       timer0_output,
    input  wire logic       timer0_output_en,
    input  wire logic       timer1_output,
    input  wire logic       timer1_output_en,
    input  wire logic       timer2_output_a,
    input  wire logic       timer2_output_a_en,
    input  wire logic       timer2_output_b,
    input  wire logic       timer2_output_b_en,
    output logic            irq_input,
    output logic            timer0_clock_input,
    output logic            timer1_clock_input,
    output logic            timer2_clock_input,
    input  wire logic       sleep_mode,
    output logic            wake_request
);

    // ----------------------------------------
    // register state
    // ----------------------------------------

    logic [7:0]                 port_data_latch_reg;
    logic [7:0]                 port_direction_reg;
    logic [7:0]                 port_pullup_enable_reg;
    logic [7:0]                 port_wake_enable_reg;
    logic [3:0]                 remap_lock_key_reg;
    logic                       irq_timer1clk_location_reg;
    prc_pkg::prc_timer_loc_t    timer_pin_location_reg;
    logic [7:0]                 analog_select_reg;
    logic                       adc_power_reg;
    logic [7:0]                 rdata_reg;
    logic                       wake_reg;

    // ----------------------------------------
    // pin input synchronisers
    // ----------------------------------------

    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic [7:0] sync3_reg;
    logic [7:0] pin_level_reg;
    logic [7:0] pin_level_prev_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_sync
            // three stages; level accepted once stages two and three agree
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    sync1_reg[gi]          <= 1'b1;
                    sync2_reg[gi]          <= 1'b1;
                    sync3_reg[gi]          <= 1'b1;
                    pin_level_reg[gi]      <= 1'b1;
                    pin_level_prev_reg[gi] <= 1'b1;
                end else begin
                    sync1_reg[gi]          <= pin_in[gi];
                    sync2_reg[gi]          <= sync1_reg[gi];
                    sync3_reg[gi]          <= sync2_reg[gi];
                    if (sync2_reg[gi] == sync3_reg[gi]) begin
                        pin_level_reg[gi] <= sync3_reg[gi];
                    end
                    pin_level_prev_reg[gi] <= pin_level_reg[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // register read view
    // ----------------------------------------

    logic [7:0] port_view;
    logic [7:0] remap_view;
    logic [7:0] read_view;

    // input pins show the pin level, output pins show the latch
    assign port_view = (port_direction_reg & pin_level_reg)
                     | (~port_direction_reg & port_data_latch_reg);

    // reserved bit is never stored and reads zero
    always_comb begin
        remap_view = 8'h00;
        remap_view[`PRC_KEY_MSB:`PRC_KEY_LSB] = remap_lock_key_reg;
        remap_view[`PRC_RSV_BIT] = 1'b0;
        remap_view[`PRC_IRQ_LOC_BIT] = irq_timer1clk_location_reg;
        remap_view[`PRC_TMR_LOC_MSB:`PRC_TMR_LOC_LSB] = timer_pin_location_reg;
    end

    // address decode for reads; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            `PRC_ADDR_DATA:    read_view = port_view;
            `PRC_ADDR_DIR:     read_view = port_direction_reg;
            `PRC_ADDR_PULLUP:  read_view = port_pullup_enable_reg;
            `PRC_ADDR_WAKE:    read_view = port_wake_enable_reg;
            `PRC_ADDR_REMAP:   read_view = remap_view;
            `PRC_ADDR_ANALOG:  read_view = analog_select_reg;
            `PRC_ADDR_ADC_CTL: read_view = {7'h00, adc_power_reg};
            default:           read_view = 8'h00;
        endcase
    end

    // ----------------------------------------
    // write path with bit read-modify-write
    // ----------------------------------------

    logic [7:0] bit_mask;
    logic       bit_op;
    logic       write_hit;
    logic [7:0] write_value;

    assign bit_mask = 8'h01 << reg_bit_index;
    assign bit_op   = reg_bit_set | reg_bit_clr;

    // whole port is read, one bit changed, all bits written back
    always_comb begin
        write_hit   = reg_wr_en | bit_op;
        write_value = reg_wdata;
        if (!reg_wr_en && reg_bit_set) begin
            write_value = read_view | bit_mask;
        end else if (!reg_wr_en && reg_bit_clr) begin
            write_value = read_view & ~bit_mask;
        end
    end

    // data latch; all ones after reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_data_latch_reg <= `PRC_RST_DATA;
        end else if (write_hit && reg_addr == `PRC_ADDR_DATA) begin
            port_data_latch_reg <= write_value;
        end
    end

    // direction; all inputs after reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_direction_reg <= `PRC_RST_DIR;
        end else if (write_hit && reg_addr == `PRC_ADDR_DIR) begin
            port_direction_reg <= write_value;
        end
    end

    // pull-up enables
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_pullup_enable_reg <= `PRC_RST_PULLUP;
        end else if (write_hit && reg_addr == `PRC_ADDR_PULLUP) begin
            port_pullup_enable_reg <= write_value;
        end
    end

    // wake-up enables; all disabled after reset
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            port_wake_enable_reg <= `PRC_RST_WAKE;
        end else if (write_hit && reg_addr == `PRC_ADDR_WAKE) begin
            port_wake_enable_reg <= write_value;
        end
    end

    // remap: key always writable, selection only under the unlock key
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            remap_lock_key_reg         <= `PRC_RST_KEY;
            irq_timer1clk_location_reg <= `PRC_RST_IRQ_LOC;
            timer_pin_location_reg     <= prc_pkg::prc_timer_loc_t'(`PRC_RST_TMR_LOC);
        end else if (write_hit && reg_addr == `PRC_ADDR_REMAP) begin
            remap_lock_key_reg <= write_value[`PRC_KEY_MSB:`PRC_KEY_LSB];
            if (remap_lock_key_reg == `PRC_KEY_UNLOCK) begin
                irq_timer1clk_location_reg <= write_value[`PRC_IRQ_LOC_BIT];
                timer_pin_location_reg     <= prc_pkg::prc_timer_loc_t'(
                    write_value[`PRC_TMR_LOC_MSB:`PRC_TMR_LOC_LSB]);
            end
        end
    end

    // analog channel selects; shared pins start analog
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            analog_select_reg <= `PRC_RST_ANALOG;
        end else if (write_hit && reg_addr == `PRC_ADDR_ANALOG) begin
            analog_select_reg <= write_value;
        end
    end

    // converter power stays off until software turns it on
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            adc_power_reg <= `PRC_RST_ADC_ON;
        end else if (write_hit && reg_addr == `PRC_ADDR_ADC_CTL) begin
            adc_power_reg <= write_value[`PRC_ADC_ON_BIT];
        end
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd_en) begin
            rdata_reg <= read_view;
        end
    end

    assign reg_rdata = rdata_reg;

    // ----------------------------------------
    // remap decode
    // ----------------------------------------

    prc_pkg::prc_pin_idx_t pin_tmr0_out;
    prc_pkg::prc_pin_idx_t pin_tmr1_out;
    prc_pkg::prc_pin_idx_t pin_tmr2_b;
    prc_pkg::prc_pin_idx_t pin_tmr2_a;
    prc_pkg::prc_pin_idx_t pin_irq;
    logic [11:0]           tmr_pin_group;

    // four fixed maps for the timer group: t0/timer2_clock_input, t1/timer0_clock_input, t2b, t2a
    always_comb begin
        unique case (timer_pin_location_reg)
            prc_pkg::PRC_LOC_A: tmr_pin_group = {3'h3, 3'h4, 3'h5, 3'h6};
            prc_pkg::PRC_LOC_B: tmr_pin_group = {3'h3, 3'h4, 3'h0, 3'h1};
            prc_pkg::PRC_LOC_C: tmr_pin_group = {3'h5, 3'h6, 3'h2, 3'h7};
            prc_pkg::PRC_LOC_D: tmr_pin_group = {3'h2, 3'h7, 3'h5, 3'h6};
        endcase
    end

    // split the selected map into one pin index per timer signal
    assign {pin_tmr0_out, pin_tmr1_out, pin_tmr2_b, pin_tmr2_a} = tmr_pin_group;

    // external interrupt and timer1 clock share one location
    assign pin_irq = irq_timer1clk_location_reg ? `PRC_PIN_IRQ_HI
                                                : `PRC_PIN_IRQ_LO;

    // ----------------------------------------
    // function inputs from pins
    // ----------------------------------------

    logic [7:0] digital_level;

    // analog pins give the digital functions a low, inactive level
    assign digital_level = pin_level_reg & ~analog_select_reg;

    assign irq_input          = digital_level[pin_irq];
    assign timer1_clock_input = digital_level[pin_irq];
    assign timer2_clock_input = digital_level[pin_tmr0_out];
    assign timer0_clock_input = digital_level[pin_tmr1_out];

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------

    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            // timer output overrides the latch on its selected pin
            assign pin_out[gi] =
                (timer0_output_en   && pin_tmr0_out == 3'(gi)) ? timer0_output   :
                (timer1_output_en   && pin_tmr1_out == 3'(gi)) ? timer1_output   :
                (timer2_output_a_en && pin_tmr2_a   == 3'(gi)) ? timer2_output_a :
                (timer2_output_b_en && pin_tmr2_b   == 3'(gi)) ? timer2_output_b :
                port_data_latch_reg[gi];

            // drive only digital outputs; analog pins stay released
            assign pin_oe[gi] = ~port_direction_reg[gi]
                              & ~analog_select_reg[gi];

            // pull-up only on inputs, never on an enabled analog channel
            assign pin_pullup_on[gi] = port_pullup_enable_reg[gi]
                                     & port_direction_reg[gi]
                                     & ~analog_select_reg[gi];
        end
    endgenerate

    assign pin_analog_on = analog_select_reg;
    assign adc_power_on  = adc_power_reg;

    // ----------------------------------------
    // wake-up
    // ----------------------------------------

    logic [7:0] fall_edge;

    assign fall_edge = pin_level_prev_reg & ~pin_level_reg;

    // any enabled falling edge in sleep or idle gives a one-cycle pulse
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= sleep_mode && |(fall_edge & port_wake_enable_reg);
        end
    end

    assign wake_request = wake_reg;

endmodule
